// *** rtl/hfq_defs.svh ***
`ifndef HFQ_DEFS_SVH
`define HFQ_DEFS_SVH
// ----------------------------------------
// device register offsets
// ----------------------------------------
`define HFQ_OFF_RXHS 8'h7C
`define HFQ_OFF_FRAME_BYTE_SIZE 8'h7E
`define HFQ_OFF_TXQC 8'h80
`define HFQ_OFF_RXQC 8'h82
`define HFQ_OFF_ISR 8'h92
`define HFQ_OFF_TXNS 8'h9E
`define HFQ_OFF_RXFC 8'h9C
`define HFQ_OFF_TXMA 8'h78
// ----------------------------------------
// field positions
// ----------------------------------------
`define HFQ_HS_CRC 0
`define HFQ_HS_RUNT 1
`define HFQ_BC_MASK 16'h0FFF
`define HFQ_TX_MAN 0
`define HFQ_TX_MON 1
`define HFQ_TX_AUTO 2
`define HFQ_TX_MASK 16'h0007
`define HFQ_RQ_FRM 10
`define HFQ_RQ_BYTE 11
`define HFQ_RQ_DUR 12
`define HFQ_RQ_WMASK 16'h03FF
`define HFQ_IS_TXSP 6
`define HFQ_IS_RX 13
// ----------------------------------------
// host controller axi registers
// ----------------------------------------
`define HFQ_A_CMD 4'h0
`define HFQ_A_ADDR 4'h1
`define HFQ_A_WDATA 4'h2
`define HFQ_A_RDATA 4'h3
`define HFQ_A_STAT 4'h4
`define HFQ_A_CLR 4'h5
`define HFQ_A_EN 4'h6
`define HFQ_CMD_WR 0
`define HFQ_CMD_RD 1
`define HFQ_OKAY 2'b00
`define HFQ_SLVERR 2'b10
`define HFQ_ZERO16 16'h0000
`define HFQ_ZERO32 32'h0000_0000
`endif

// *** rtl/hfq_pkg.sv ***
package hfq_pkg;
  typedef enum logic [2:0] {
    HFQ_IDLE = 3'b001,
    HFQ_REQ = 3'b010,
    HFQ_DONE = 3'b100
  } hfq_hst_e;
  typedef logic [15:0] hfq_word_t;
endpackage

// *** rtl/hfq_link_if.sv ***
`timescale 1ns/1ps
interface hfq_link_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface // hfq_link_if

// *** rtl/hfq_device.sv ***
`timescale 1ns/1ps
`include "hfq_defs.svh"
module hfq_device (
  input wire logic mclk,
  input wire logic reset_n,
  hfq_link_if.dev link,
  input wire logic passBadFrame,
  input wire logic frameValid,
  input wire logic frameRunt,
  input wire logic frameCrcError,
  input wire logic [11:0] frameByteSize,
  input wire logic [7:0] pendingFrames,
  input wire logic durationOver,
  input wire logic byteOver,
  input wire logic frameOver,
  input wire logic txFrameDone,
  input wire logic [12:0] txSpaceFree,
  output logic frameDeliver,
  output logic txEnqueue,
  output logic txIrq
);
  logic [1:0] hdrStatus, next_hdrStatus;
  logic [11:0] byteSize, next_byteSize;
  logic [2:0] txCmd, next_txCmd;
  logic [9:0] rxCtl, next_rxCtl;
  logic [2:0] thrHit, next_thrHit;
  logic [12:0] sizeReq, next_sizeReq;
  logic ack, next_ack;
  logic [15:0] rdata, next_rdata;
  logic next_frameDeliver, next_txEnqueue, next_txIrq;
  logic wrHit;
  assign link.ack = ack;
  assign link.rdata = rdata;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    wrHit = link.req && link.wr && !ack;
    next_hdrStatus = hdrStatus;
    next_byteSize = byteSize;
    next_txCmd = txCmd;
    next_rxCtl = rxCtl;
    next_thrHit = thrHit;
    next_sizeReq = sizeReq;
    next_txIrq = txIrq;
    next_txEnqueue = 1'b0;
    next_frameDeliver = 1'b0;
    // one entry latched per frame, re-readable until the next frame overwrites it
    if (frameValid) begin
      next_hdrStatus[`HFQ_HS_RUNT] = frameRunt;
      next_hdrStatus[`HFQ_HS_CRC] = frameCrcError;
      next_byteSize = frameByteSize;
      next_frameDeliver = passBadFrame || !(frameRunt || frameCrcError);
    end
    // auto mode models one frame per pulse, so it alternates while set
    if (txCmd[`HFQ_TX_AUTO])
      next_txEnqueue = !txEnqueue;
    if (txFrameDone) begin
      next_txCmd[`HFQ_TX_MAN] = 1'b0;
      next_txCmd[`HFQ_TX_MON] = 1'b0;
    end
    if (wrHit) begin
      case (link.addr)
        `HFQ_OFF_TXQC: begin
          next_txCmd = link.wdata[2:0];
          // one frame per manual command; ignored while pending or under auto
          if (link.wdata[`HFQ_TX_MAN] && !txCmd[`HFQ_TX_MAN] && !txCmd[`HFQ_TX_AUTO] && !link.wdata[`HFQ_TX_AUTO])
            next_txEnqueue = 1'b1;
        end
        `HFQ_OFF_RXQC: next_rxCtl = link.wdata[9:0];
        `HFQ_OFF_TXNS: next_sizeReq = link.wdata[12:0];
        `HFQ_OFF_ISR: begin
          if (link.wdata[`HFQ_IS_TXSP])
            next_txIrq = 1'b0;
          if (link.wdata[`HFQ_IS_RX])
            next_thrHit = {durationOver, byteOver, frameOver};
        end
        default: ;
      endcase
    end
    // space event after the clear so that it wins in a shared cycle
    if (txCmd[`HFQ_TX_MON] && ({3'b000, txSpaceFree} >= {3'b000, sizeReq}))
      next_txIrq = 1'b1;
    next_ack = link.req && !ack;
    next_rdata = `HFQ_ZERO16;
    if (link.req && !link.wr) begin
      case (link.addr)
        `HFQ_OFF_RXHS: next_rdata = {14'h0000, hdrStatus};
        `HFQ_OFF_FRAME_BYTE_SIZE: next_rdata = {4'h0, byteSize} & `HFQ_BC_MASK;
        `HFQ_OFF_TXQC: next_rdata = {13'h0000, txCmd} & `HFQ_TX_MASK;
        `HFQ_OFF_RXQC: next_rdata = {3'h0, thrHit, rxCtl};
        `HFQ_OFF_ISR: next_rdata = {9'h000, txIrq, 6'h00};
        `HFQ_OFF_RXFC: next_rdata = {8'h00, pendingFrames};
        `HFQ_OFF_TXMA: next_rdata = {3'h0, txSpaceFree};
        `HFQ_OFF_TXNS: next_rdata = {3'h0, sizeReq};
        default: next_rdata = `HFQ_ZERO16;
      endcase
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hdrStatus <= 2'b00;
      byteSize <= 12'h000;
      txCmd <= 3'b000;
      rxCtl <= 10'h000;
      thrHit <= 3'b000;
      sizeReq <= 13'h0000;
      ack <= 1'b0;
      rdata <= `HFQ_ZERO16;
      frameDeliver <= 1'b0;
      txEnqueue <= 1'b0;
      txIrq <= 1'b0;
    end else begin
      hdrStatus <= next_hdrStatus;
      byteSize <= next_byteSize;
      txCmd <= next_txCmd;
      rxCtl <= next_rxCtl;
      thrHit <= next_thrHit;
      sizeReq <= next_sizeReq;
      ack <= next_ack;
      rdata <= next_rdata;
      frameDeliver <= next_frameDeliver;
      txEnqueue <= next_txEnqueue;
      txIrq <= next_txIrq;
    end
  end
endmodule // hfq_device

// *** rtl/hfq_host.sv ***
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "hfq_defs.svh"
module hfq_host (
  input wire logic mclk,
  input wire logic reset_n,
  hfq_link_if.host link,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  function automatic logic [3:0] wordIdx(input logic [31:0] a);
    wordIdx = a[5:2];
  endfunction
  hfq_pkg::hfq_hst_e st, next_st;
  logic [7:0] devAddr, next_devAddr;
  logic [15:0] devWdata, next_devWdata, devRdata, next_devRdata;
  logic cmdWr, next_cmdWr;
  logic [1:0] stat, next_stat, en, next_en;
  logic req, next_req, wr, next_wr;
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [31:0] awA, next_awA, wD, next_wD;
  logic awr, next_awr, wrd, next_wrd, bv, next_bv, arr, next_arr, rv, next_rv;
  logic [1:0] br, next_br, rr, next_rr;
  logic [31:0] rd, next_rd;
  logic next_irq, cmdGo;
  assign link.req = req;
  assign link.wr = wr;
  assign link.addr = devAddr;
  assign link.wdata = devWdata;
  assign s_axi_awready = awr;
  assign s_axi_wready = wrd;
  assign s_axi_bvalid = bv;
  assign s_axi_bresp = br;
  assign s_axi_arready = arr;
  assign s_axi_rvalid = rv;
  assign s_axi_rresp = rr;
  assign s_axi_rdata = rd;
  // ----------------------------------------
  // axi slave and device access sequencer
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_devAddr = devAddr;
    next_devWdata = devWdata;
    next_devRdata = devRdata;
    next_cmdWr = cmdWr;
    next_stat = stat;
    next_en = en;
    next_req = req;
    next_wr = wr;
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awA = awA;
    next_wD = wD;
    next_awr = 1'b0;
    next_wrd = 1'b0;
    next_bv = bv && !s_axi_bready;
    next_br = br;
    next_arr = 1'b0;
    next_rv = rv && !s_axi_rready;
    next_rr = rr;
    next_rd = rd;
    cmdGo = 1'b0;
    if (s_axi_awvalid && !awHeld && !awr && !bv) begin
      next_awr = 1'b1;
      next_awHeld = 1'b1;
      next_awA = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld && !wrd && !bv) begin
      next_wrd = 1'b1;
      next_wHeld = 1'b1;
      next_wD = s_axi_wdata;
    end
    if (awHeld && wHeld && !bv) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bv = 1'b1;
      next_br = `HFQ_OKAY;
      case (wordIdx(awA))
        `HFQ_A_CMD: cmdGo = st == hfq_pkg::HFQ_IDLE;
        `HFQ_A_ADDR: next_devAddr = wD[7:0];
        `HFQ_A_WDATA: next_devWdata = wD[15:0];
        `HFQ_A_CLR: next_stat = stat & ~wD[1:0];
        `HFQ_A_EN: next_en = wD[1:0];
        default: next_br = `HFQ_SLVERR;
      endcase
      if (cmdGo) begin
        // host must not set manual enqueue with auto enqueue
        if (devAddr == `HFQ_OFF_TXQC && wD[`HFQ_CMD_WR] && devWdata[`HFQ_TX_AUTO])
          next_devWdata[`HFQ_TX_MAN] = 1'b0;
        next_cmdWr = wD[`HFQ_CMD_WR];
        next_st = hfq_pkg::HFQ_REQ;
        next_req = 1'b1;
        next_wr = wD[`HFQ_CMD_WR];
      end
    end
    if (s_axi_arvalid && !arr && !rv) begin
      next_arr = 1'b1;
      next_rv = 1'b1;
      next_rr = `HFQ_OKAY;
      case (wordIdx(s_axi_araddr))
        `HFQ_A_ADDR: next_rd = {24'h00_0000, devAddr};
        `HFQ_A_WDATA: next_rd = {16'h0000, devWdata};
        `HFQ_A_RDATA: next_rd = {16'h0000, devRdata};
        `HFQ_A_STAT: next_rd = {29'h0000_0000, st == hfq_pkg::HFQ_IDLE, stat};
        `HFQ_A_EN: next_rd = {30'h0000_0000, en};
        default: begin
          next_rd = `HFQ_ZERO32;
          next_rr = `HFQ_SLVERR;
        end
      endcase
    end
    case (st)
      hfq_pkg::HFQ_IDLE: ;
      hfq_pkg::HFQ_REQ: begin
        if (link.ack) begin
          next_req = 1'b0;
          if (!cmdWr)
            next_devRdata = link.rdata;
          next_st = hfq_pkg::HFQ_DONE;
        end
      end
      hfq_pkg::HFQ_DONE: begin
        // done event wins over a same-cycle clear
        next_stat[0] = 1'b1;
        if (!cmdWr && devAddr == `HFQ_OFF_RXHS && link.rdata[`HFQ_HS_CRC +: 2] != 2'b00)
          next_stat[1] = 1'b1;
        next_st = hfq_pkg::HFQ_IDLE;
      end
      default: next_st = hfq_pkg::HFQ_IDLE;
    endcase
    next_irq = |(next_stat & next_en);
  end
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= hfq_pkg::HFQ_IDLE;
      devAddr <= 8'h00;
      devWdata <= `HFQ_ZERO16;
      devRdata <= `HFQ_ZERO16;
      cmdWr <= 1'b0;
      stat <= 2'b00;
      en <= 2'b00;
      req <= 1'b0;
      wr <= 1'b0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awA <= `HFQ_ZERO32;
      wD <= `HFQ_ZERO32;
      awr <= 1'b0;
      wrd <= 1'b0;
      bv <= 1'b0;
      br <= `HFQ_OKAY;
      arr <= 1'b0;
      rv <= 1'b0;
      rr <= `HFQ_OKAY;
      rd <= `HFQ_ZERO32;
      irq <= 1'b0;
    end else begin
      st <= next_st;
      devAddr <= next_devAddr;
      devWdata <= next_devWdata;
      devRdata <= next_devRdata;
      cmdWr <= next_cmdWr;
      stat <= next_stat;
      en <= next_en;
      req <= next_req;
      wr <= next_wr;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awA <= next_awA;
      wD <= next_wD;
      awr <= next_awr;
      wrd <= next_wrd;
      bv <= next_bv;
      br <= next_br;
      arr <= next_arr;
      rv <= next_rv;
      rr <= next_rr;
      rd <= next_rd;
      irq <= next_irq;
    end
  end
endmodule // hfq_host

// *** test/hfq_link_properties.sv ***
`timescale 1ns/1ps
`include "hfq_defs.svh"
module hfq_link_properties (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic passBadFrame,
  input wire logic frameValid,
  input wire logic frameRunt,
  input wire logic frameCrcError,
  input wire logic frameDeliver
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // link steps and frame outcome
  // ----------------------------------------
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !req;
  endsequence
  sequence s_bad;
    frameValid && (frameRunt || frameCrcError);
  endsequence
  a_link_answer: assert property (s_take |=> s_answer)
    else $error("link answer not one cycle after request");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("link acknowledge longer than one cycle");
  a_req_held: assert property (s_take |=> req && $stable(addr) && $stable(wr))
    else $error("link request changed before answer");
  a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("link acknowledge without request");
  a_good_deliver: assert property (frameValid && !frameRunt && !frameCrcError |=> frameDeliver)
    else $error("good frame not delivered");
  a_bad_withheld: assert property (s_bad ##0 !passBadFrame |=> !frameDeliver)
    else $error("bad frame delivered");
  a_bad_passed: assert property (s_bad ##0 passBadFrame |=> frameDeliver)
    else $error("bad frame withheld although passing");
  a_deliver_cause: assert property (frameDeliver |-> $past(frameValid))
    else $error("delivery without frame");
  a_count_reserved: assert property (ack && !wr && addr == `HFQ_OFF_FRAME_BYTE_SIZE |-> rdata[15:12] == 4'h0)
    else $error("byte count reserved bits set");
  a_txcmd_reserved: assert property (ack && !wr && addr == `HFQ_OFF_TXQC |-> rdata[15:3] == 13'h0000)
    else $error("tx command reserved bits set");
  a_rxcmd_reserved: assert property (ack && !wr && addr == `HFQ_OFF_RXQC |-> rdata[15:13] == 3'h0)
    else $error("rx command reserved bits set");
endmodule // hfq_link_properties

// *** test/testbench.sv ***
`timescale 1ns/1ps
`include "hfq_defs.svh"
module testbench;
  logic mclk = 0, reset_n = 0, passBadFrame = 0, frameValid = 0, frameRunt = 0, frameCrcError = 0;
  logic durationOver = 0, byteOver = 0, frameOver = 0, txFrameDone = 0;
  logic [11:0] frameByteSize = 0;
  logic [7:0] pendingFrames = 0;
  logic [12:0] txSpaceFree = 0;
  logic frameDeliver, txEnqueue, txIrq, irq, awReady, wReady, bValid, arReady, rValid;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [31:0] awAddr = 0, wData = 0, arAddr = 0, rData, t;
  logic [1:0] bResp, rResp;
  logic [15:0] r;
  int n_mismatch = 0, n_compared = 0, cyc = 0, nEnq = 0;
  hfq_link_if link ();
  hfq_device hfq_device_inst (.mclk(mclk), .reset_n(reset_n), .link(link), .passBadFrame(passBadFrame),
    .frameValid(frameValid), .frameRunt(frameRunt), .frameCrcError(frameCrcError), .frameByteSize(frameByteSize),
    .pendingFrames(pendingFrames), .durationOver(durationOver), .byteOver(byteOver), .frameOver(frameOver),
    .txFrameDone(txFrameDone), .txSpaceFree(txSpaceFree), .frameDeliver(frameDeliver), .txEnqueue(txEnqueue),
    .txIrq(txIrq));
  hfq_host hfq_host_inst (.mclk(mclk), .reset_n(reset_n), .link(link), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .irq(irq));
  hfq_link_properties hfq_link_properties_inst (.mclk(mclk), .reset_n(reset_n), .req(link.req), .wr(link.wr),
    .addr(link.addr), .ack(link.ack), .rdata(link.rdata), .passBadFrame(passBadFrame), .frameValid(frameValid),
    .frameRunt(frameRunt), .frameCrcError(frameCrcError), .frameDeliver(frameDeliver));
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (txEnqueue === 1'b1) nEnq++;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ----------------------------------------
  // bus and link helpers
  // ----------------------------------------
  task summarize;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  function logic [31:0] ar(input logic [3:0] i);
    return {26'h000_0000, i, 2'b00};
  endfunction
  function logic expDel(input logic rn, input logic ce, input logic p);
    return !(rn || ce) || p;
  endfunction
  task axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    do begin
      @(posedge mclk);
      if (awReady) awValid <= 0;
      if (wReady) wValid <= 0;
    end while (!bValid);
    bReady <= 0;
  endtask
  task axr(input logic [31:0] a);
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    do begin
      @(posedge mclk);
      if (arReady) arValid <= 0;
    end while (!rValid);
    t = rData;
    rReady <= 0;
  endtask
  // clear first so the done bit polled below belongs to this access
  task dev(input logic w, input logic [7:0] a, input logic [15:0] d);
    axw(ar(`HFQ_A_CLR), 32'h0000_0001);
    axw(ar(`HFQ_A_ADDR), {24'h00_0000, a});
    axw(ar(`HFQ_A_WDATA), {16'h0000, d});
    axw(ar(`HFQ_A_CMD), 32'(w));
    t = 0;
    while (!t[0]) axr(ar(`HFQ_A_STAT));
    axr(ar(`HFQ_A_RDATA));
    r = t[15:0];
  endtask
  task rd(input logic [7:0] a);
    dev(1'b0, a, 16'h0000);
  endtask
  task pulseDone;
    @(posedge mclk);
    txFrameDone <= 1;
    @(posedge mclk);
    txFrameDone <= 0;
  endtask
  task frame(input logic rn, input logic ce, input logic [11:0] sz, input logic p);
    @(posedge mclk);
    frameValid <= 1;
    frameRunt <= rn;
    frameCrcError <= ce;
    frameByteSize <= sz;
    passBadFrame <= p;
    pendingFrames <= 8'(1 + $urandom % 4);
    @(posedge mclk);
    frameValid <= 0;
    @(posedge mclk);
    chk(16'(frameDeliver), 16'(expDel(rn, ce, p)), "deliver");
    axw(ar(`HFQ_A_CLR), 32'h0000_0002);
    rd(`HFQ_OFF_RXHS);
    chk(16'(r[1:0]), 16'({rn, ce}), "header status");
    axr(ar(`HFQ_A_STAT));
    chk(16'(t[2:1]), 16'({1'b1, rn || ce}), "access status");
    rd(`HFQ_OFF_RXFC);
    chk(r, {8'h00, pendingFrames}, "pending frames");
    // entry must survive repeated reads
    repeat (2) begin
      rd(`HFQ_OFF_FRAME_BYTE_SIZE);
      chk(r, {4'h0, sz}, "byte count");
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(56902));
    repeat (10) @(posedge mclk);
    reset_n <= 1;
    frame(1'b0, 1'b0, 12'hFFF, 1'b0);
    frame(1'b1, 1'b1, 12'h000, 1'b0);
    repeat (6) frame(1'($urandom), 1'($urandom), 12'($urandom), 1'($urandom));
    dev(1'b1, `HFQ_OFF_RXQC, 16'hFFFF);
    for (int i = 0; i < 8; i++) begin
      {durationOver, byteOver, frameOver} <= 3'(i);
      dev(1'b1, `HFQ_OFF_ISR, 16'h2000);
      {durationOver, byteOver, frameOver} <= ~3'(i);
      rd(`HFQ_OFF_RXQC);
      chk(r, {3'b000, 3'(i), 10'h3FF}, "rx queue command");
    end
    dev(1'b1, `HFQ_OFF_TXNS, 16'h0100);
    rd(`HFQ_OFF_TXNS);
    chk(r, 16'h0100, "size request");
    dev(1'b1, `HFQ_OFF_TXQC, 16'h0002);
    chk(16'(txIrq), 16'h0000, "space irq early");
    txSpaceFree <= 13'h0100;
    for (int i = 0; i < 50 && txIrq !== 1'b1; i++) @(posedge mclk);
    chk(16'(txIrq), 16'h0001, "space irq");
    rd(`HFQ_OFF_TXQC);
    chk(r, 16'h0002, "monitor held");
    rd(`HFQ_OFF_TXMA);
    chk(r, 16'h0100, "space free");
    pulseDone();
    rd(`HFQ_OFF_TXQC);
    chk(r, 16'h0000, "monitor cleared");
    dev(1'b1, `HFQ_OFF_ISR, 16'h0040);
    chk(16'(txIrq), 16'h0000, "space irq cleared");
    nEnq = 0;
    dev(1'b1, `HFQ_OFF_TXQC, 16'h0001);
    rd(`HFQ_OFF_TXQC);
    chk(r, 16'h0001, "manual held");
    chk(16'(nEnq), 16'h0001, "manual enqueue");
    pulseDone();
    rd(`HFQ_OFF_TXQC);
    chk(r, 16'h0000, "manual cleared");
    nEnq = 0;
    dev(1'b1, `HFQ_OFF_TXQC, 16'hFFFF);
    rd(`HFQ_OFF_TXQC);
    chk(r, 16'h0006, "auto with manual off");
    chk(16'(nEnq > 0), 16'h0001, "auto enqueue");
    dev(1'b1, `HFQ_OFF_TXQC, 16'h0000);
    rd(8'h10);
    chk(r, 16'h0000, "unmapped link read");
    axw(32'h0000_001C, 32'h0000_0001);
    chk(16'(bResp), 16'(`HFQ_SLVERR), "unmapped bus write");
    axr(ar(`HFQ_A_CLR));
    chk(16'(rResp), 16'(`HFQ_SLVERR), "write-only read");
    axw(ar(`HFQ_A_EN), 32'h0000_0001);
    rd(`HFQ_OFF_FRAME_BYTE_SIZE);
    repeat (2) @(posedge mclk);
    chk(16'(irq), 16'h0001, "irq raised");
    axw(ar(`HFQ_A_EN), 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk(16'(irq), 16'h0000, "irq masked");
    axw(ar(`HFQ_A_CLR), 32'h0000_0001);
    axw(ar(`HFQ_A_EN), 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(16'(irq), 16'h0000, "irq cleared");
    summarize();
  end
endmodule // testbench
